// >>> rtl/bwm_breaker_wear_monitor.sv
// breaker wear monitor with AXI4-Lite register slave
`timescale 1ns/1ps
`include "bwm_params.svh"

module bwm_breaker_wear_monitor #(
  parameter int ADDR_W = 8,
  parameter int TRIP_W = 8,
  parameter int TS_TICK_CYCLES = `BWM_TS_TICK_US * `BWM_CLK_MHZ
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [TRIP_W-1:0] openCmd,
  input wire bwm_pkg::bwm_cur_t phaseCur,
  input wire logic phaseCurValid,
  output logic alarm1,
  output logic alarm2,
  output bwm_pkg::bwm_cond_t condition,
  output logic wearEvent
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // log2 in q5.8: msb position plus eight bits of mantissa
  function automatic logic [12:0] log2q(input logic [17:0] x);
    logic [4:0] k;
    logic [17:0] n;
    k = 5'h00;
    for (int i = 0; i < 18; i++) begin
      if (x[i]) k = 5'(i);
    end
    n = x << (`BWM_LOG_MSB - k);
    return {k, n[16:9]};
  endfunction

  function automatic logic [17:0] exp2q(input logic [12:0] e);
    logic [25:0] v;
    v = {17'h00000, 1'b1, e[7:0]} << e[12:8];
    if (e[12:8] > `BWM_LOG_MSB) return 18'h3ffff;
    return v[25:8];
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    for (int b = 0; b < 4; b++) begin
      if (be[b]) old[8*b +: 8] = wd[8*b +: 8];
    end
    return old;
  endfunction

  function automatic logic anyBelow(input logic [2:0][17:0] lv, input logic [17:0] lim);
    return (lv[0] < lim) || (lv[1] < lim) || (lv[2] < lim);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bwm_pkg::bwm_cfg_t cfg;
  bwm_pkg::bwm_state_t state;
  bwm_pkg::bwm_cur_t curHold;
  bwm_pkg::bwm_cur_t capCur;
  bwm_pkg::bwm_rec_t logMem [`BWM_LOG_DEPTH];
  logic [2:0][17:0] left;
  logic [2:0][17:0] lastDed;
  logic [1:0] phase;
  logic [25:0] divQ;
  logic [13:0] divRem;
  logic [12:0] divDen;
  logic [4:0] divCnt;
  logic [12:0] expo;
  logic [17:0] ded;
  logic [TRIP_W-1:0] openCmdQ;
  logic alm1Real;
  logic alm2Real;
  logic [31:0] brkOps;
  logic [31:0] alm1Cnt;
  logic [31:0] alm2Cnt;
  logic [31:0] tickCnt;
  logic [31:0] stamp;
  logic [3:0] logWr;
  logic [3:0] logNum;
  logic [3:0] logSel;
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic [31:0] rdMux;

  // ------------------------------------------------------------
  // AXI4-Lite decode
  // ------------------------------------------------------------
  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire awTake = s_axi_awvalid && s_axi_awready;
  wire wTake = s_axi_wvalid && s_axi_wready;
  wire arTake = s_axi_arvalid && s_axi_arready;
  wire [ADDR_W-1:0] wrAddr = awHeld ? awAddr : s_axi_awaddr;
  wire [31:0] wrDataIn = wHeld ? wData : s_axi_wdata;
  wire [3:0] wrStrbIn = wHeld ? wStrb : s_axi_wstrb;
  wire wrFire = (awHeld || awTake) && (wHeld || wTake);
  wire wrMapped = (wrAddr[1:0] == 2'b00) && (wrAddr <= `BWM_REG_LOG_TIME);
  wire rdMapped = (s_axi_araddr[1:0] == 2'b00) && (s_axi_araddr <= `BWM_REG_LOG_TIME);
  wire wrCtrl = wrFire && (wrAddr == `BWM_REG_CTRL);
  wire [31:0] ctrlWord = {14'h0000, 2'b00, 5'h00, cfg.tripSel, 2'b00, cfg.forceSt, 1'b0,
                          cfg.forceEn, cfg.alm2En, cfg.alm1En};
  wire [31:0] ctrlNew = mergeBytes(ctrlWord, wrDataIn, wrStrbIn);
  wire clrCnt = wrCtrl && ctrlNew[`BWM_CTRL_CLR_CNT];
  wire reload = wrCtrl && ctrlNew[`BWM_CTRL_RELOAD];
  wire bwm_pkg::bwm_rec_t selRec = logMem[logSel];

  // ------------------------------------------------------------
  // wear evaluation datapath
  // ------------------------------------------------------------
  wire trigEdge = openCmd[cfg.tripSel] && !openCmdQ[cfg.tripSel];
  wire [17:0] capAmp = {2'b00, capCur.amp[phase]};
  wire [12:0] lCap = log2q(capAmp);
  wire [12:0] lINom = log2q({2'b00, cfg.curNom});
  wire [12:0] lIMax = log2q({2'b00, cfg.curMax});
  wire [12:0] lNNom = log2q(cfg.opsNom);
  wire [12:0] lNMax = log2q(cfg.opsMax);
  wire [12:0] spanN = lNNom - lNMax;
  // flat or inverted characteristic falls back to one nominal operation
  wire charFlat = (cfg.opsNom <= cfg.opsMax) || (cfg.curMax <= cfg.curNom);
  wire [25:0] interpNum = (lCap - lINom) * spanN;
  wire [13:0] remShift = {divRem[12:0], divQ[25]};
  wire remGe = remShift >= {1'b0, divDen};
  wire [12:0] divExpo = (divQ > {13'h0000, spanN}) ? spanN : divQ[12:0];
  wire [17:0] expVal = exp2q(expo);
  wire [17:0] leftNext = (left[phase] > ded) ? left[phase] - ded : 18'h00000;
  wire alm1Out = cfg.forceEn ? (cfg.forceSt == bwm_pkg::COND_ALARM1) : alm1Real;
  wire alm2Out = cfg.forceEn ? (cfg.forceSt == bwm_pkg::COND_ALARM2) : alm2Real;

  // ------------------------------------------------------------
  // register read mux
  // ------------------------------------------------------------
  always_comb begin
    rdMux = 32'h00000000;
    case (s_axi_araddr)
      `BWM_REG_CTRL: rdMux = ctrlWord;
      `BWM_REG_OPS_NOM: rdMux = {14'h0000, cfg.opsNom};
      `BWM_REG_OPS_MAX: rdMux = {14'h0000, cfg.opsMax};
      `BWM_REG_CUR_NOM: rdMux = {16'h0000, cfg.curNom};
      `BWM_REG_CUR_MAX: rdMux = {16'h0000, cfg.curMax};
      `BWM_REG_ALM1_SET: rdMux = {14'h0000, cfg.alm1Set};
      `BWM_REG_ALM2_SET: rdMux = {14'h0000, cfg.alm2Set};
      `BWM_REG_STATUS: rdMux = {24'h000000, 1'b0, state != bwm_pkg::ST_IDLE, alm2Real,
                                alm1Real, 2'b00, condition};
      `BWM_REG_BRK_OPS: rdMux = brkOps;
      `BWM_REG_ALM1_CNT: rdMux = alm1Cnt;
      `BWM_REG_ALM2_CNT: rdMux = alm2Cnt;
      `BWM_REG_LEFT_L1: rdMux = {14'h0000, left[0]};
      `BWM_REG_LEFT_L2: rdMux = {14'h0000, left[1]};
      `BWM_REG_LEFT_L3: rdMux = {14'h0000, left[2]};
      `BWM_REG_LOG_SEL: rdMux = {28'h0000000, logSel};
      `BWM_REG_LOG_INFO: rdMux = {24'h000000, logNum, logWr};
      `BWM_REG_LOG_CUR_L1: rdMux = {16'h0000, selRec.cur.amp[0]};
      `BWM_REG_LOG_CUR_L2: rdMux = {16'h0000, selRec.cur.amp[1]};
      `BWM_REG_LOG_CUR_L3: rdMux = {16'h0000, selRec.cur.amp[2]};
      `BWM_REG_LOG_DED_L1: rdMux = {14'h0000, selRec.ded[0]};
      `BWM_REG_LOG_DED_L2: rdMux = {14'h0000, selRec.ded[1]};
      `BWM_REG_LOG_DED_L3: rdMux = {14'h0000, selRec.ded[2]};
      `BWM_REG_LOG_LEFT_L1: rdMux = {14'h0000, selRec.left[0]};
      `BWM_REG_LOG_LEFT_L2: rdMux = {14'h0000, selRec.left[1]};
      `BWM_REG_LOG_LEFT_L3: rdMux = {14'h0000, selRec.left[2]};
      `BWM_REG_LOG_TIME: rdMux = selRec.stamp;
      default: rdMux = 32'h00000000;
    endcase
  end

  // ------------------------------------------------------------
  // bus channels
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= '0;
      wData <= 32'h00000000;
      wStrb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BWM_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `BWM_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (awTake && !wrFire) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (wTake && !wrFire) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `BWM_RESP_OKAY : `BWM_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (arTake) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMapped ? rdMux : 32'h00000000;
        s_axi_rresp <= rdMapped ? `BWM_RESP_OKAY : `BWM_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // settings: written only by software, no setting group input
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg.alm1En <= 1'b0;
      cfg.alm2En <= 1'b0;
      cfg.forceEn <= 1'b0;
      cfg.forceSt <= bwm_pkg::COND_NORMAL;
      cfg.tripSel <= 3'h0;
      cfg.opsNom <= `BWM_RST_OPS_NOM;
      cfg.opsMax <= `BWM_RST_OPS_MAX;
      cfg.curNom <= `BWM_RST_CUR_NOM;
      cfg.curMax <= `BWM_RST_CUR_MAX;
      cfg.alm1Set <= `BWM_RST_ALM1_SET;
      cfg.alm2Set <= `BWM_RST_ALM2_SET;
      logSel <= 4'h0;
    end else if (wrFire) begin
      case (wrAddr)
        `BWM_REG_CTRL: begin
          cfg.alm1En <= ctrlNew[`BWM_CTRL_ALM1_EN];
          cfg.alm2En <= ctrlNew[`BWM_CTRL_ALM2_EN];
          cfg.forceEn <= ctrlNew[`BWM_CTRL_FORCE_EN];
          cfg.forceSt <= ctrlNew[`BWM_CTRL_FORCE_LSB +: 2];
          cfg.tripSel <= ctrlNew[`BWM_CTRL_TRIP_LSB +: 3];
        end
        `BWM_REG_OPS_NOM: cfg.opsNom <= 18'(mergeBytes({14'h0000, cfg.opsNom}, wrDataIn,
                                                       wrStrbIn));
        `BWM_REG_OPS_MAX: cfg.opsMax <= 18'(mergeBytes({14'h0000, cfg.opsMax}, wrDataIn,
                                                       wrStrbIn));
        `BWM_REG_CUR_NOM: cfg.curNom <= 16'(mergeBytes({16'h0000, cfg.curNom}, wrDataIn,
                                                       wrStrbIn));
        `BWM_REG_CUR_MAX: cfg.curMax <= 16'(mergeBytes({16'h0000, cfg.curMax}, wrDataIn,
                                                       wrStrbIn));
        `BWM_REG_ALM1_SET: cfg.alm1Set <= 18'(mergeBytes({14'h0000, cfg.alm1Set}, wrDataIn,
                                                         wrStrbIn));
        `BWM_REG_ALM2_SET: cfg.alm2Set <= 18'(mergeBytes({14'h0000, cfg.alm2Set}, wrDataIn,
                                                         wrStrbIn));
        `BWM_REG_LOG_SEL: logSel <= (wrDataIn[3:0] < 4'(`BWM_LOG_DEPTH)) ? wrDataIn[3:0] : logSel;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // measurement hold and time stamp
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      curHold <= '0;
      openCmdQ <= '0;
      tickCnt <= 32'h00000000;
      stamp <= 32'h00000000;
    end else begin
      openCmdQ <= openCmd;
      if (phaseCurValid) curHold <= phaseCur;
      if (tickCnt == 32'(TS_TICK_CYCLES - 1)) begin
        tickCnt <= 32'h00000000;
        stamp <= stamp + 32'h00000001;
      end else begin
        tickCnt <= tickCnt + 32'h00000001;
      end
    end
  end

  // ------------------------------------------------------------
  // evaluation sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state <= bwm_pkg::ST_IDLE;
      capCur <= '0;
      phase <= 2'h0;
      divQ <= 26'h0000000;
      divRem <= 14'h0000;
      divDen <= 13'h0000;
      divCnt <= 5'h00;
      expo <= 13'h0000;
      ded <= 18'h00000;
      lastDed <= '0;
      left <= {3{`BWM_RST_OPS_NOM}};
      wearEvent <= 1'b0;
      logWr <= 4'h0;
      logNum <= 4'h0;
    end else begin
      wearEvent <= 1'b0;
      case (state)
        bwm_pkg::ST_IDLE: begin
          // an edge while an evaluation runs is not queued
          if (trigEdge) begin
            capCur <= phaseCurValid ? phaseCur : curHold;
            phase <= 2'h0;
            state <= bwm_pkg::ST_PREP;
          end
        end
        bwm_pkg::ST_PREP: begin
          if (charFlat || capAmp <= {2'b00, cfg.curNom}) begin
            ded <= 18'h00001;
            state <= bwm_pkg::ST_APPLY;
          end else if (capAmp >= {2'b00, cfg.curMax}) begin
            expo <= spanN;
            state <= bwm_pkg::ST_EXPAND;
          end else begin
            divQ <= interpNum;
            divRem <= 14'h0000;
            divDen <= lIMax - lINom;
            divCnt <= 5'h00;
            state <= bwm_pkg::ST_DIV;
          end
        end
        bwm_pkg::ST_DIV: begin
          divRem <= remGe ? remShift - {1'b0, divDen} : remShift;
          divQ <= {divQ[24:0], remGe};
          divCnt <= divCnt + 5'h01;
          if (divCnt == `BWM_DIV_STEPS - 5'h01) state <= bwm_pkg::ST_EXPAND;
        end
        bwm_pkg::ST_EXPAND: begin
          if (divCnt == `BWM_DIV_STEPS) begin
            expo <= divExpo;
            divCnt <= 5'h00;
          end else begin
            ded <= (expVal == 18'h00000) ? 18'h00001 : expVal;
            state <= bwm_pkg::ST_APPLY;
          end
        end
        bwm_pkg::ST_APPLY: begin
          left[phase] <= leftNext;
          lastDed[phase] <= ded;
          if (phase == 2'h2) begin
            state <= bwm_pkg::ST_LOG;
          end else begin
            phase <= phase + 2'h1;
            state <= bwm_pkg::ST_PREP;
          end
        end
        bwm_pkg::ST_LOG: begin
          logWr <= (logWr == 4'(`BWM_LOG_DEPTH - 1)) ? 4'h0 : logWr + 4'h1;
          if (logNum != 4'(`BWM_LOG_DEPTH)) logNum <= logNum + 4'h1;
          wearEvent <= 1'b1;
          state <= bwm_pkg::ST_IDLE;
        end
        default: state <= bwm_pkg::ST_IDLE;
      endcase
      // reload restores the initial value on every phase
      if (reload) left <= {3{cfg.opsNom}};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (state == bwm_pkg::ST_LOG) logMem[logWr] <= {capCur, lastDed, left, stamp};
  end

  // ------------------------------------------------------------
  // alarms, condition and counters
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      alm1Real <= 1'b0;
      alm2Real <= 1'b0;
      alarm1 <= 1'b0;
      alarm2 <= 1'b0;
      condition <= bwm_pkg::COND_NORMAL;
      brkOps <= 32'h00000000;
      alm1Cnt <= 32'h00000000;
      alm2Cnt <= 32'h00000000;
    end else begin
      alm1Real <= cfg.alm1En && anyBelow(left, cfg.alm1Set);
      alm2Real <= cfg.alm2En && anyBelow(left, cfg.alm2Set);
      alarm1 <= alm1Out;
      alarm2 <= alm2Out;
      condition <= alm2Out ? bwm_pkg::COND_ALARM2 :
                   alm1Out ? bwm_pkg::COND_ALARM1 : bwm_pkg::COND_NORMAL;
      // clear first, so an event in the same cycle still counts
      brkOps <= (clrCnt ? 32'h00000000 : brkOps) +
                {31'h00000000, state == bwm_pkg::ST_LOG};
      alm1Cnt <= (clrCnt ? 32'h00000000 : alm1Cnt) +
                 {31'h00000000, alm1Out && !alarm1};
      alm2Cnt <= (clrCnt ? 32'h00000000 : alm2Cnt) +
                 {31'h00000000, alm2Out && !alarm2};
    end
  end
endmodule

// >>> common/bwm_params.svh
// constants of the breaker wear monitor: offsets, field positions, reset values, timing
`ifndef BWM_PARAMS_SVH
`define BWM_PARAMS_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define BWM_REG_CTRL 8'h00
`define BWM_REG_OPS_NOM 8'h04
`define BWM_REG_OPS_MAX 8'h08
`define BWM_REG_CUR_NOM 8'h0c
`define BWM_REG_CUR_MAX 8'h10
`define BWM_REG_ALM1_SET 8'h14
`define BWM_REG_ALM2_SET 8'h18
`define BWM_REG_STATUS 8'h1c
`define BWM_REG_BRK_OPS 8'h20
`define BWM_REG_ALM1_CNT 8'h24
`define BWM_REG_ALM2_CNT 8'h28
`define BWM_REG_LEFT_L1 8'h2c
`define BWM_REG_LEFT_L2 8'h30
`define BWM_REG_LEFT_L3 8'h34
`define BWM_REG_LOG_SEL 8'h38
`define BWM_REG_LOG_INFO 8'h3c
`define BWM_REG_LOG_CUR_L1 8'h40
`define BWM_REG_LOG_CUR_L2 8'h44
`define BWM_REG_LOG_CUR_L3 8'h48
`define BWM_REG_LOG_DED_L1 8'h4c
`define BWM_REG_LOG_DED_L2 8'h50
`define BWM_REG_LOG_DED_L3 8'h54
`define BWM_REG_LOG_LEFT_L1 8'h58
`define BWM_REG_LOG_LEFT_L2 8'h5c
`define BWM_REG_LOG_LEFT_L3 8'h60
`define BWM_REG_LOG_TIME 8'h64
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define BWM_CTRL_ALM1_EN 0
`define BWM_CTRL_ALM2_EN 1
`define BWM_CTRL_FORCE_EN 2
`define BWM_CTRL_FORCE_LSB 4
`define BWM_CTRL_TRIP_LSB 8
`define BWM_CTRL_CLR_CNT 16
`define BWM_CTRL_RELOAD 17
// ------------------------------------------------------------
// reset values (currents in 0.01 kA)
// ------------------------------------------------------------
`define BWM_RST_OPS_NOM 18'h0c350
`define BWM_RST_OPS_MAX 18'h00064
`define BWM_RST_CUR_NOM 16'h0064
`define BWM_RST_CUR_MAX 16'h07d0
`define BWM_RST_ALM1_SET 18'h003e8
`define BWM_RST_ALM2_SET 18'h00064
// ------------------------------------------------------------
// timing and sizes
// ------------------------------------------------------------
`define BWM_CLK_MHZ 10
`define BWM_TS_TICK_US 1000
`define BWM_LOG_DEPTH 12
`define BWM_DIV_STEPS 5'h1a
`define BWM_LOG_MSB 5'h11
`define BWM_RESP_OKAY 2'b00
`define BWM_RESP_SLVERR 2'b10
`endif

// >>> common/bwm_pkg.sv
// types shared by the breaker wear monitor
package bwm_pkg;
  typedef enum logic [1:0] {
    COND_NORMAL = 2'b00,
    COND_ALARM1 = 2'b01,
    COND_ALARM2 = 2'b10
  } bwm_cond_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PREP = 3'b001,
    ST_DIV = 3'b010,
    ST_EXPAND = 3'b011,
    ST_APPLY = 3'b100,
    ST_LOG = 3'b101
  } bwm_state_t;

  typedef struct packed {
    logic [2:0][15:0] amp;
  } bwm_cur_t;

  typedef struct packed {
    logic alm1En;
    logic alm2En;
    logic forceEn;
    logic [1:0] forceSt;
    logic [2:0] tripSel;
    logic [17:0] opsNom;
    logic [17:0] opsMax;
    logic [15:0] curNom;
    logic [15:0] curMax;
    logic [17:0] alm1Set;
    logic [17:0] alm2Set;
  } bwm_cfg_t;

  typedef struct packed {
    bwm_cur_t cur;
    logic [2:0][17:0] ded;
    logic [2:0][17:0] left;
    logic [31:0] stamp;
  } bwm_rec_t;
endpackage

// >>> test/bwm_assertions.sv
// concurrent checks on the wear monitor ports
`timescale 1ns/1ps
module bwm_assertions (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic wearEvent,
  input wire logic alarm1,
  input wire logic alarm2,
  input wire logic [1:0] condition
);
  // ------------------------------------------------------------
  // bus handshake, event pulse and condition
  // ------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> s_axi_bvalid) else $error("write answer late");
  r_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read answer without request");
  wear_pulse_a: assert property (wearEvent |=> !wearEvent)
    else $error("event pulse too long");
  cond_match_a: assert property (condition == {alarm2, alarm1 && !alarm2})
    else $error("condition disagrees with alarms");
endmodule

bind bwm_breaker_wear_monitor bwm_assertions i_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .wearEvent(wearEvent), .alarm1(alarm1), .alarm2(alarm2),
  .condition(condition)
);

// >>> test/bwm_partner.sv
// far-side model: open command contacts and phase current feed
`timescale 1ns/1ps
module bwm_partner #(
  parameter int CUR_PERIOD = 50000
) (
  input wire logic clk_sys,
  input wire bwm_pkg::bwm_cur_t curSet,
  output logic [7:0] openCmd,
  output bwm_pkg::bwm_cur_t phaseCur,
  output logic phaseCurValid
);
  // ------------------------------------------------------------
  // measurement refresh and contact action
  // ------------------------------------------------------------
  int tick = 0;
  initial begin
    openCmd = 8'h00;
    phaseCur = '0;
    phaseCurValid = 1'b0;
  end
  // default period is 5 ms at 10 MHz; shortened in the bench to save run time
  always @(posedge clk_sys) begin
    tick <= (tick == CUR_PERIOD - 1) ? 0 : tick + 1;
    phaseCurValid <= (tick == CUR_PERIOD - 1);
    if (tick == CUR_PERIOD - 1) begin
      phaseCur <= curSet;
    end
  end
  // held a few cycles so a level-sampling trigger cannot miss it
  task automatic fire(input int b);
    openCmd[b] <= 1'b1;
    repeat (3) @(posedge clk_sys);
    openCmd[b] <= 1'b0;
    @(posedge clk_sys);
  endtask
endmodule

// >>> test/tb.sv
// self-checking bench for the breaker wear monitor
`timescale 1ns/1ps
`include "bwm_params.svh"
module tb;
  // ------------------------------------------------------------
  // signals, design and far side
  // ------------------------------------------------------------
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awAddr = 8'h00, arAddr = 8'h00, openCmd;
  logic [31:0] wData = 32'h0, rData;
  logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
  logic awReady, wReady, bValid, arReady, rValid, wearEvent, alarm1, alarm2, phaseCurValid;
  logic [1:0] bResp, rResp;
  bwm_pkg::bwm_cur_t curSet = '0, phaseCur;
  bwm_pkg::bwm_cond_t condition;
  logic [31:0] dflt [6] = '{`BWM_RST_OPS_NOM, `BWM_RST_OPS_MAX, `BWM_RST_CUR_NOM,
    `BWM_RST_CUR_MAX, `BWM_RST_ALM1_SET, `BWM_RST_ALM2_SET};
  int errors = 0, checked = 0;
  bwm_breaker_wear_monitor #(.TS_TICK_CYCLES(10)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awAddr), .s_axi_awprot(3'b000),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arprot(3'b000), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .openCmd(openCmd), .phaseCur(phaseCur), .phaseCurValid(phaseCurValid),
    .alarm1(alarm1), .alarm2(alarm2), .condition(condition), .wearEvent(wearEvent));
  bwm_partner #(.CUR_PERIOD(20)) i_part (.clk_sys(clk_sys), .curSet(curSet),
    .openCmd(openCmd), .phaseCur(phaseCur), .phaseCurValid(phaseCurValid));
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  // ------------------------------------------------------------
  // bus cycles and comparison
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    r = bResp;
    bReady <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  // fixed window longer than the slowest evaluation
  task automatic op(input int b, output logic got);
    got = 1'b0;
    i_part.fire(b);
    repeat (150) begin
      @(posedge clk_sys);
      if (wearEvent === 1'b1) got = 1'b1;
    end
  endtask
  task automatic final_report();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic got;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rc(`BWM_REG_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) rc(8'(4 * i + 4), dflt[i]);
    rd(8'h68, d, r);
    chk(d, 32'h0);
    chk(r, `BWM_RESP_SLVERR);
    wr(8'h6c, 32'h1, r);
    chk(r, `BWM_RESP_SLVERR);
    curSet <= {16'h0000, 16'h0032, 16'h0064};
    repeat (25) @(posedge clk_sys);
    op(0, got);
    chk(got, 1'b1);
    for (int i = 0; i < 3; i++)
      rc(8'(`BWM_REG_LEFT_L1 + 4 * i), `BWM_RST_OPS_NOM - 1);
    rc(`BWM_REG_BRK_OPS, 32'h1);
    wr(`BWM_REG_CTRL, 32'h100, r);
    op(0, got);
    chk(got, 1'b0);
    op(1, got);
    chk(got, 1'b1);
    wr(`BWM_REG_OPS_NOM, 32'h3, r);
    wr(`BWM_REG_ALM1_SET, 32'h2, r);
    wr(`BWM_REG_ALM2_SET, 32'h1, r);
    wr(`BWM_REG_CTRL, 32'h20103, r);
    for (int k = 1; k <= 4; k++) begin
      op(1, got);
      rc(`BWM_REG_LEFT_L3, 32'((k < 3) ? 3 - k : 0));
      chk(alarm1, (k > 1));
      chk(alarm2, (k > 2));
      chk(condition, (k > 2) ? bwm_pkg::COND_ALARM2 :
        (k > 1) ? bwm_pkg::COND_ALARM1 : bwm_pkg::COND_NORMAL);
    end
    rc(`BWM_REG_ALM1_CNT, 32'h1);
    rc(`BWM_REG_ALM2_CNT, 32'h1);
    rc(`BWM_REG_LOG_INFO, 32'h66);
    wr(`BWM_REG_CTRL, 32'h107, r);
    repeat (3) @(posedge clk_sys);
    chk(condition, bwm_pkg::COND_NORMAL);
    wr(`BWM_REG_CTRL, 32'h117, r);
    repeat (3) @(posedge clk_sys);
    chk(alarm2, 1'b0);
    chk(condition, bwm_pkg::COND_ALARM1);
    wr(`BWM_REG_CTRL, 32'h10000, r);
    rc(`BWM_REG_BRK_OPS, 32'h0);
    // powers of two keep the log scale exact: max point 64, midpoint 8
    wr(`BWM_REG_OPS_NOM, 32'h400, r);
    wr(`BWM_REG_OPS_MAX, 32'h10, r);
    wr(`BWM_REG_CUR_NOM, 32'h40, r);
    wr(`BWM_REG_CUR_MAX, 32'h400, r);
    wr(`BWM_REG_CTRL, 32'h20000, r);
    curSet <= {16'h0000, 16'h0100, 16'h0400};
    repeat (25) @(posedge clk_sys);
    op(0, got);
    rc(`BWM_REG_LEFT_L1, 32'h3c0);
    rc(`BWM_REG_LEFT_L2, 32'h3f8);
    rc(`BWM_REG_LEFT_L3, 32'h3ff);
    wr(`BWM_REG_LOG_SEL, 32'h6, r);
    rc(`BWM_REG_LOG_DED_L2, 32'h8);
    rc(`BWM_REG_LOG_CUR_L1, 32'h400);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    final_report();
  end
endmodule
